// file: odc_pkg.sv
package odc_pkg;
   localparam int CH_N        = 8;
   localparam int BITS_FRAME  = 8;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] SHIFT_RST = 8'h00;
   localparam int CLK_MHZ     = 100;
   // Fault blanking time after a commanded change on channels 0 and 1.
   localparam int BLANK_US    = 150;
   localparam int BLANK_CYC   = BLANK_US * CLK_MHZ;
   localparam int PAR_CH_N    = 2;

   typedef struct packed {
      logic sel_n;
      logic sck;
      logic mosi;
   } odc_spi_t;

   typedef enum logic [2:0] {
      ODC_IDLE  = 3'b001,
      ODC_FRAME = 3'b010,
      ODC_DONE  = 3'b100
   } odc_state_t;
endpackage

// file: odc_par_chan.sv
`timescale 1ns/1ps
// Fault checker for one parallel-driven channel.
module odc_par_chan
   import odc_pkg::*;
#(
   parameter int BLANK = BLANK_CYC
) (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic drive_active,
   input  wire logic cmd_on,
   input  wire logic out_state,
   input  wire logic comp_high,
   output logic      feedback
);
   logic [31:0] blank_q;
   logic [31:0] blank_d;
   logic        on_prev_q;
   logic        on_prev_d;
   logic        fault_q;
   logic        fault_d;

   always_comb begin
      on_prev_d = cmd_on;
      blank_d   = blank_q;
      fault_d   = fault_q;
      if (cmd_on != on_prev_q) begin
         blank_d = 32'(BLANK);
      end else if (blank_q != 32'h0) begin
         blank_d = blank_q - 32'h1;
      end
      if (!drive_active) begin
         fault_d = 1'b0;
      end else if (blank_q == 32'h0 && cmd_on == on_prev_q
                   && out_state != cmd_on) begin
         fault_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         blank_q   <= 32'h0;
         on_prev_q <= 1'b0;
         fault_q   <= 1'b0;
      end else begin
         blank_q   <= blank_d;
         on_prev_q <= on_prev_d;
         fault_q   <= fault_d;
      end
   end

   // Under parallel drive a high bit means no fault; otherwise status.
   always_comb begin
      if (drive_active) begin
         feedback = ~fault_q;
      end else begin
         feedback = comp_high;
      end
   end

   a_blank_no_fault: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (blank_q != 32'h0 && drive_active && fault_q == 1'b0)
      |=> fault_q == 1'b0)
      else $error("fault latched during blanking");
endmodule

// file: odc_serial_ctrl.sv
`timescale 1ns/1ps
module odc_serial_ctrl
   import odc_pkg::*;
#(
   parameter int CH    = CH_N,
   parameter int BLANK = BLANK_CYC
) (
   input  wire logic          ref_clk,
   input  wire logic          sys_rst,
   input  wire logic          reset_n,
   input  wire odc_spi_t      spi_in,
   output logic               miso_o,
   output logic               miso_oe,
   input  wire logic [1:0]    parallel_drive_n,
   input  wire logic [CH-1:0] comp_above_ref,
   input  wire logic [CH-1:0] out_of_sat,
   output logic [CH-1:0]      driver_on,
   output logic [CH-1:0]      channel_command_bits
);
   odc_spi_t        s1_q;
   odc_spi_t        s2_q;
   odc_spi_t        s3_q;
   logic [1:0]      r1_q;
   logic [1:0]      r2_q;
   logic [1:0]      pd1_q;
   logic [1:0]      pd2_q;
   logic [CH-1:0]   cmp1_q;
   logic [CH-1:0]   cmp2_q;
   logic [CH-1:0]   oos1_q;
   logic [CH-1:0]   oos2_q;
   odc_state_t      st_q;
   odc_state_t      st_d;
   logic [CH-1:0]   sh_q;
   logic [CH-1:0]   sh_d;
   logic [CH-1:0]   lat_q;
   logic [CH-1:0]   lat_d;
   logic [CH-1:0]   flt_q;
   logic [CH-1:0]   flt_d;
   logic [CH-1:0]   drv_q;
   logic [CH-1:0]   drv_d;
   logic [2:0]      cnt_q;
   logic [2:0]      cnt_d;
   logic            full_q;
   logic            full_d;
   logic            miso_q;
   logic            miso_d;
   logic            sel_fall;
   logic            sel_rise;
   logic            sck_rise;
   logic            sck_fall;
   logic            chip_rst;
   logic [1:0]      pd_act;
   logic [CH-1:0]   cmd_on;
   logic [CH-1:0]   channel_feedback_bits;

   // Two-stage synchronisers, three stages for reset_n and the SPI lines; only stage two and later are read.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q  <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0};
         s2_q  <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0};
         s3_q  <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0};
         r1_q  <= 2'h0;
         r2_q  <= 2'h0;
         pd1_q <= 2'h3;
         pd2_q <= 2'h3;
         cmp1_q <= '0;
         cmp2_q <= '0;
         oos1_q <= '0;
         oos2_q <= '0;
      end else begin
         s1_q  <= spi_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         r1_q  <= {r1_q[0], ~reset_n};
         r2_q  <= r1_q;
         pd1_q <= parallel_drive_n;
         pd2_q <= pd1_q;
         cmp1_q <= comp_above_ref;
         cmp2_q <= cmp1_q;
         oos1_q <= out_of_sat;
         oos2_q <= oos1_q;
      end
   end

   assign chip_rst = r2_q[1];
   assign pd_act   = ~pd2_q;
   assign sel_fall = s3_q.sel_n & ~s2_q.sel_n;
   assign sel_rise = ~s3_q.sel_n & s2_q.sel_n;
   assign sck_rise = ~s3_q.sck & s2_q.sck & ~s2_q.sel_n;
   assign sck_fall = s3_q.sck & ~s2_q.sck & ~s2_q.sel_n;

   // Serial bit ORed with parallel drive; serial on always wins.
   always_comb begin
      cmd_on    = lat_q;
      cmd_on[0] = lat_q[0] | pd_act[0];
      cmd_on[1] = lat_q[1] | pd_act[1];
   end
   assign driver_on            = drv_q;
   assign channel_command_bits = lat_q;

   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : g_fb
         if (g < PAR_CH_N) begin : g_par
            odc_par_chan #(.BLANK(BLANK)) u_par (
               .ref_clk      (ref_clk),
               .sys_rst      (sys_rst),
               .drive_active (pd_act[g]),
               .cmd_on       (cmd_on[g]),
               .out_state    (~cmp2_q[g]),
               .comp_high    (cmp2_q[g]),
               .feedback     (channel_feedback_bits[g])
            );
         end else begin : g_stat
            assign channel_feedback_bits[g] = cmp2_q[g];
         end
      end
   endgenerate

   always_comb begin
      st_d   = st_q;
      sh_d   = sh_q;
      lat_d  = lat_q;
      cnt_d  = cnt_q;
      full_d = full_q;
      miso_d = miso_q;
      flt_d  = flt_q | (driver_on & oos2_q);
      if (!s2_q.sel_n) begin
         flt_d = '0;
      end
      case (st_q)
         ODC_IDLE: begin
            if (sel_fall) begin
               sh_d   = channel_feedback_bits;
               miso_d = channel_feedback_bits[CH-1];
               cnt_d  = 3'h0;
               full_d = 1'b0;
               st_d   = ODC_FRAME;
            end
         end
         ODC_FRAME: begin
            if (sck_rise) begin
               miso_d = sh_q[CH-1];
            end
            if (sck_fall) begin
               sh_d   = {sh_q[CH-2:0], s2_q.mosi};
               cnt_d  = cnt_q + 3'h1;
               full_d = (cnt_q == 3'(BITS_FRAME - 1));
            end
            if (sel_rise) begin
               st_d = ODC_DONE;
            end
         end
         ODC_DONE: begin
            if (full_q) begin
               lat_d = sh_q;
            end
            st_d = ODC_IDLE;
         end
         default: st_d = ODC_IDLE;
      endcase
      if (chip_rst) begin
         lat_d = LATCH_RST;
         flt_d = '0;
      end
      // Reset turns every driver off, parallel-driven ones included.
      drv_d = chip_rst ? '0 : (cmd_on & ~flt_d);
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q   <= ODC_IDLE;
         sh_q   <= SHIFT_RST;
         lat_q  <= LATCH_RST;
         flt_q  <= '0;
         cnt_q  <= 3'h0;
         full_q <= 1'b0;
         miso_q <= 1'b0;
         drv_q  <= '0;
      end else begin
         st_q   <= st_d;
         sh_q   <= sh_d;
         lat_q  <= lat_d;
         flt_q  <= flt_d;
         cnt_q  <= cnt_d;
         full_q <= full_d;
         miso_q <= miso_d;
         drv_q  <= drv_d;
      end
   end

   assign miso_o  = miso_q;
   assign miso_oe = ~s2_q.sel_n;

   a_oe_in_frame: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      miso_oe |-> (st_q == ODC_FRAME || sel_fall))
      else $error("miso enabled outside a frame");
   a_load_status: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (st_q == ODC_IDLE && sel_fall) |=> sh_q == $past(channel_feedback_bits))
      else $error("shift register not loaded on select fall");
   a_shift_msb: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (st_q == ODC_FRAME && sck_fall && !sel_rise)
      |=> sh_q[0] == $past(s2_q.mosi))
      else $error("mosi bit not shifted in");
   a_latch_load: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (st_q == ODC_DONE && full_q && !chip_rst) |=> lat_q == $past(sh_q))
      else $error("latch not loaded from shift register");
   a_idle_hold: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (st_q == ODC_IDLE && !sel_fall) |=> $stable(sh_q))
      else $error("shift register changed while deselected");
   a_partial_drop: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (st_q == ODC_DONE && !full_q && !chip_rst) |=> $stable(lat_q))
      else $error("partial frame reached the latch");
   a_reset_clear: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      chip_rst |=> lat_q == LATCH_RST && driver_on == '0)
      else $error("reset did not clear latch and drivers");
   a_or_drive: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      ((lat_q[0] || pd_act[0]) && !flt_d[0] && !chip_rst) |=> driver_on[0])
      else $error("channel 0 not driven on");
   a_fault_off: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (driver_on[2] && oos2_q[2] && s2_q.sel_n) |=> !driver_on[2])
      else $error("fault latch did not turn channel off");
   a_sel_clear: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !s2_q.sel_n |=> flt_q == '0)
      else $error("select low did not clear fault latches");
endmodule

// file: odc_spi_master.sv
`timescale 1ns/1ps
// Bus master with a 125 ns serial clock that idles low between frames.
module odc_spi_master
   import odc_pkg::*;
(
   output odc_spi_t   spi,
   input  wire logic  miso
);
   logic [7:0] rx;
   event       done;
   initial spi = '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0};
   task automatic xfer(input logic [15:0] tx, input int nb);
      rx = 8'h00;
      spi.sel_n = 1'b0;
      #62.5;
      for (int i = nb - 1; i >= 0; i--) begin
         spi.mosi = tx[i];
         spi.sck = 1'b1;
         #62.5;
         rx = {rx[6:0], miso};
         spi.sck = 1'b0;
         #62.5;
      end
      // The data line no longer holds the last bit once deselected.
      spi.mosi = ~spi.mosi;
      spi.sel_n = 1'b1;
      #200;
      ->done;
   endtask
   task automatic noise(input int n);
      repeat (n) begin
         spi.mosi = ~spi.mosi;
         spi.sck = 1'b1;
         #62.5;
         spi.sck = 1'b0;
         #62.5;
      end
   endtask
endmodule

// file: tb_octal_driver_serial_control_diag.sv
`timescale 1ns/1ps
module tb_octal_driver_serial_control_diag
   import odc_pkg::*;
();
   localparam int BL = 10;
   typedef struct packed {logic [7:0] rx, lat, on;} odc_exp_t;
   logic       ref_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       reset_n = 1'b1;
   logic [1:0] par_n   = 2'b11;
   logic [7:0] comp    = 8'h00;
   logic [7:0] oos     = 8'h00;
   logic       miso_o, miso_oe;
   logic [7:0] drv_on, latch;
   odc_spi_t   spi;
   wire        miso_w  = miso_oe ? miso_o : 1'bz;
   int         fail_count = 0;
   int         comparisons = 0;
   odc_exp_t   q[$];

   always #5 ref_clk = ~ref_clk;

   odc_serial_ctrl #(.BLANK(BL)) dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .reset_n(reset_n),
      .spi_in(spi), .miso_o(miso_o), .miso_oe(miso_oe),
      .parallel_drive_n(par_n), .comp_above_ref(comp),
      .out_of_sat(oos), .driver_on(drv_on),
      .channel_command_bits(latch));
   odc_spi_master m_u (.spi(spi), .miso(miso_w));

   task automatic chk(input string n, input logic [7:0] e, g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic print_verdict;
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic frame(input logic [15:0] tx, input int nb,
                        input logic [7:0] rx, lat, on);
      @(negedge ref_clk);
      q.push_back('{rx, lat, on});
      m_u.xfer(tx, nb);
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   always @(m_u.done) begin
      odc_exp_t e;
      e = q.pop_front();
      chk("miso byte", e.rx, m_u.rx);
      chk("latch", e.lat, latch);
      chk("driver on", e.on, drv_on);
      chk("miso enable", 8'h00, {7'h00, miso_oe});
   end

   initial begin
      logic [7:0] b;
      void'($urandom(32'h57CE6577));
      settle(16);
      sys_rst = 1'b0;
      settle(4);
      chk("latch", 8'h00, latch);
      for (int i = 0; i < 5; i++) begin
         b = $urandom;
         comp = $urandom;
         // The same byte twice, as a status check would do it.
         repeat (2) frame({8'h00, b}, 8, comp, b, b);
      end
      frame(16'h007F, 7, comp >> 1, b, b);
      frame(16'hA53C, 16, 8'hA5, 8'h3C, 8'h3C);
      m_u.noise(6);
      settle(10);
      chk("latch", 8'h3C, latch);
      reset_n = 1'b0;
      settle(8);
      chk("latch", 8'h00, latch);
      chk("driver on", 8'h00, drv_on);
      reset_n = 1'b1;
      // The pin still reads off while channel 0 switches on.
      comp = 8'h01;
      par_n = 2'b10;
      settle(3);
      comp = 8'h00;
      settle(BL + 10);
      chk("driver on", 8'h01, drv_on);
      frame(16'h0002, 8, 8'h01, 8'h02, 8'h03);
      comp = 8'h01;
      settle(BL + 10);
      frame(16'h0002, 8, 8'h00, 8'h02, 8'h03);
      par_n = 2'b11;
      comp = 8'h00;
      settle(BL + 10);
      frame(16'h0004, 8, 8'h00, 8'h04, 8'h04);
      oos = 8'h04;
      settle(5);
      oos = 8'h00;
      settle(5);
      chk("driver on", 8'h00, drv_on);
      frame(16'h0004, 8, 8'h00, 8'h04, 8'h04);
      print_verdict();
   end

   initial begin
      #200us;
      fail_count++;
      print_verdict();
   end
endmodule
